// [shared/tst_defs.svh]
// shared constants for the two-wire sensor target port and its controller
// assumes a 125 MHz system clock on both ends
`ifndef TST_DEFS_SVH
`define TST_DEFS_SVH

`define TST_ADDR_BASE    7'h48
`define TST_HS_CODE      5'h01
`define TST_PTR_LAST     8'h08
`define TST_PTR_BLK      8'h80
`define TST_PTR_BLK_END  8'h88
`define TST_PTR_SRST     8'h20
`define TST_PTR_CFG      8'h30
`define TST_PTR_HYS      8'h38
`define TST_PTR_LOCK     8'hC4
`define TST_KEY_LOCK     16'h5CA6
`define TST_KEY_UNLOCK   16'hEB19
`define TST_SRST_BIT     15
`define TST_CFG_POR      16'hFF9C
`define TST_HYS_POR      16'h0500
`define TST_CLK_MHZ      125
`define TST_TMO_US       17500
`define TST_TMO_CYC      (`TST_TMO_US * `TST_CLK_MHZ)
`define TST_FILT_FAST    3'h3
`define TST_FILT_HS      3'h1
`define TST_SCL_QTR_NS   625
`define TST_SCL_QTR_CYC  ((`TST_SCL_QTR_NS * `TST_CLK_MHZ) / 1000)
`define TST_REG_CMD      8'h00
`define TST_REG_STAT     8'h04

`endif

// [shared/tst_pkg.sv]
// types for the two-wire sensor target port and its controller
// constants live in tst_defs.svh
package tst_pkg;

  typedef enum logic [2:0] {
    P_IDLE, P_RX, P_RXACK, P_TX, P_TXACK, P_TXNEXT, P_WAIT
  } tst_phase_e;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_START, CMD_WRITE, CMD_READ_ACK, CMD_READ_NACK, CMD_STOP
  } tst_cmd_e;

  typedef enum logic [1:0] {
    C_IDLE, C_START, C_BIT, C_STOP
  } tst_cst_e;

  typedef struct packed {
    logic       scl_s1, scl_s2, sda_s1, sda_s2;
    logic       scl_f, sda_f, scl_q, sda_q;
    logic [2:0] scl_cnt, sda_cnt;
    logic [1:0] addr_s1, addr_s2, strap_cnt;
    logic [6:0] addr;
    tst_phase_e phase;
    logic [3:0] bitcnt;
    logic [7:0] sr, sh, ptr, hi;
    logic       got_addr, first, rw, rd_lo, busy, hs, locked;
    logic [1:0] wr_cnt;
    logic       sda_oe_n, soft_rst;
    logic [15:0] cfg, hys;
    logic [21:0] tmo, tmo_sda;
  } tst_dev_s;

  typedef struct packed {
    logic       sda_s1, sda_s2;
    tst_cst_e   st;
    logic [6:0] qcnt;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] txb, rxb;
    logic       rd, nack_out, nack_seen;
    logic       scl_oe_n, sda_oe_n;
    logic [31:0] prdata;
    logic       pready, pslverr;
  } tst_ctl_s;

endpackage : tst_pkg

// [shared/tst_if.sv]
// open-drain two-wire bus joining the controller and the sensor target
// assumes an external pull-up: a line is low only while someone drives it
`timescale 1ns/1ps
interface tst_if;
  logic ctl_scl_o;
  logic ctl_scl_oe_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  assign scl = ctl_scl_oe_n | ctl_scl_o;
  assign sda = (ctl_sda_oe_n | ctl_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport ctl (input scl, input sda, output ctl_scl_o, output ctl_scl_oe_n,
               output ctl_sda_o, output ctl_sda_oe_n);
endinterface : tst_if

// [rtl/tst_target.sv]
// sensor target end of the two-wire bus: framing, pointer, word access,
// block reads, timeout, high-speed entry, soft reset and write lock
// assumes bus lines come from another domain; temperatures are static-ish
//
`timescale 1ns/1ps
`include "tst_defs.svh"

// What this block does
// - start and stop framed by SDA under SCL
// - receiver holds SDA low on ninth clock
// - controller NACKs or stops to end reads
// - strap picks one of four addresses
// - first write byte loads the pointer
// - reads reuse last written pointer
// - high byte first, restart at high
// - word committed only at second ack
// - read ended after high byte is fine
// - block reads only from mirror range
// - block pointer auto-advances, wraps at end
// - stopped block read leaves pointer advanced
// - lines stuck low reset the interface
// - timeout releases bus, waits for start
// - controller keeps SCL at least 1 kHz
// - high-speed code unacked, filters switch
// - stop returns filters to fast mode
// - soft reset restores power-on values
// - lock key enables write protection
// - locked config and hysteresis writes dropped and not acked
// - unlock key removes write protection
// - powers up locked
module tst_target #(
  parameter int TIMEOUT_CYC = `TST_TMO_CYC
) (
  input  wire logic             i_clock,
  input  wire logic             i_reset_n,
  input  wire logic [1:0]       i_addr_sel,
  input  wire logic [8:0][15:0] i_temps,
  output logic      [15:0]      o_config,
  output logic      [15:0]      o_hysteresis,
  output logic                  o_locked,
  output logic                  o_hs_mode,
  output logic                  o_soft_reset,
  tst_if.dev                    bus
);

  tst_pkg::tst_dev_s r;
  tst_pkg::tst_dev_s next_r;

  // glitch filter: a line must differ for lim cycles before it is taken
  function automatic logic [3:0] filt_step(input logic s, input logic f,
                                           input logic [2:0] cnt,
                                           input logic [2:0] lim);
    if (s == f)
      filt_step = {f, 3'h0};
    else if (cnt >= lim - 3'h1)
      filt_step = {s, 3'h0};
    else
      filt_step = {f, cnt + 3'h1};
  endfunction : filt_step

  function automatic logic is_blk(input logic [7:0] p);
    is_blk = (p >= `TST_PTR_BLK) && (p <= `TST_PTR_BLK_END);
  endfunction : is_blk

  function automatic logic lockable(input logic [7:0] p);
    lockable = (p == `TST_PTR_CFG) || (p == `TST_PTR_HYS);
  endfunction : lockable

  function automatic logic [15:0] word_at(input logic [7:0] p,
                                          input logic [8:0][15:0] t,
                                          input logic [15:0] cfg,
                                          input logic [15:0] hys);
    if (p <= `TST_PTR_LAST || is_blk(p))
      word_at = t[p[3:0]];
    else if (p == `TST_PTR_CFG)
      word_at = cfg;
    else if (p == `TST_PTR_HYS)
      word_at = hys;
    else
      word_at = 16'h0000;
  endfunction : word_at

  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic [2:0]  lim;
  logic [15:0] cur_word;
  logic [7:0]  tx_byte;
  logic [15:0] wr_word;

  always_comb begin
    next_r = r;
    next_r.soft_rst = 1'b0;
    next_r.scl_s1 = bus.scl;
    next_r.scl_s2 = r.scl_s1;
    next_r.sda_s1 = bus.sda;
    next_r.sda_s2 = r.sda_s1;
    lim = r.hs ? `TST_FILT_HS : `TST_FILT_FAST;
    {next_r.scl_f, next_r.scl_cnt} = filt_step(r.scl_s2, r.scl_f,
                                               r.scl_cnt, lim);
    {next_r.sda_f, next_r.sda_cnt} = filt_step(r.sda_s2, r.sda_f,
                                               r.sda_cnt, lim);
    next_r.scl_q = r.scl_f;
    next_r.sda_q = r.sda_f;
    scl_rise = r.scl_f & ~r.scl_q;
    scl_fall = ~r.scl_f & r.scl_q;
    start_seen = r.scl_f & r.scl_q & r.sda_q & ~r.sda_f;
    stop_seen  = r.scl_f & r.scl_q & ~r.sda_q & r.sda_f;

    next_r.addr_s1 = i_addr_sel;
    next_r.addr_s2 = r.addr_s1;
    if (r.strap_cnt != 2'h3) begin
      next_r.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == 2'h2)
        next_r.addr = `TST_ADDR_BASE + {5'h00, r.addr_s2};
    end

    // each line timed on its own
    if (r.busy && !r.scl_f)
      next_r.tmo = r.tmo + 22'h1;
    else
      next_r.tmo = 22'h0;
    if (r.busy && !r.sda_f)
      next_r.tmo_sda = r.tmo_sda + 22'h1;
    else
      next_r.tmo_sda = 22'h0;

    // reads use stored pointer; high byte first
    cur_word = word_at(r.ptr, i_temps, r.cfg, r.hys);
    tx_byte  = r.rd_lo ? cur_word[7:0] : cur_word[15:8];
    wr_word  = {r.hi, r.sr};

    if (start_seen) begin
      next_r.phase    = tst_pkg::P_RX;
      next_r.bitcnt   = 4'h0;
      next_r.got_addr = 1'b0;
      next_r.first    = 1'b1;
      next_r.busy     = 1'b1;
      next_r.sda_oe_n = 1'b1;
      next_r.tmo      = 22'h0;
      next_r.tmo_sda  = 22'h0;
    end else if (stop_seen) begin
      next_r.phase    = tst_pkg::P_IDLE;
      next_r.busy     = 1'b0;
      next_r.hs       = 1'b0;
      next_r.sda_oe_n = 1'b1;
    end else if (r.tmo == 22'(TIMEOUT_CYC) ||
                 r.tmo_sda == 22'(TIMEOUT_CYC)) begin
      next_r.phase    = tst_pkg::P_WAIT;
      next_r.busy     = 1'b0;
      next_r.hs       = 1'b0;
      next_r.sda_oe_n = 1'b1;
      next_r.tmo      = 22'h0;
      next_r.tmo_sda  = 22'h0;
    end else begin
      case (r.phase)
        tst_pkg::P_RX: begin
          if (scl_rise) begin
            next_r.sr     = {r.sr[6:0], r.sda_f};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == 4'h8) begin
            next_r.bitcnt = 4'h0;
            next_r.phase  = tst_pkg::P_WAIT;
            if (!r.got_addr) begin
              next_r.first = 1'b0;
              if (r.first && r.sr[7:3] == `TST_HS_CODE) begin
                next_r.hs = 1'b1;
              end else if (r.sr[7:1] == r.addr) begin
                next_r.sda_oe_n = 1'b0;
                next_r.phase    = tst_pkg::P_RXACK;
                next_r.got_addr = 1'b1;
                next_r.rw       = r.sr[0];
                next_r.wr_cnt   = 2'h0;
                next_r.rd_lo    = 1'b0;
              end
            end else if (r.wr_cnt == 2'h0) begin
              next_r.ptr      = r.sr;
              next_r.sda_oe_n = 1'b0;
              next_r.phase    = tst_pkg::P_RXACK;
              next_r.wr_cnt   = 2'h1;
            end else if (r.wr_cnt == 2'h1) begin
              if (!(r.locked && lockable(r.ptr))) begin
                next_r.hi       = r.sr;
                next_r.sda_oe_n = 1'b0;
                next_r.phase    = tst_pkg::P_RXACK;
                next_r.wr_cnt   = 2'h2;
              end
            end else begin
              next_r.sda_oe_n = 1'b0;
              next_r.phase    = tst_pkg::P_RXACK;
              next_r.wr_cnt   = 2'h1;
              case (r.ptr)
                `TST_PTR_SRST: begin
                  if (wr_word[`TST_SRST_BIT]) begin
                    next_r.cfg      = `TST_CFG_POR;
                    next_r.hys      = `TST_HYS_POR;
                    next_r.locked   = 1'b1;
                    next_r.soft_rst = 1'b1;
                  end
                end
                `TST_PTR_LOCK: begin
                  if (wr_word == `TST_KEY_LOCK)
                    next_r.locked = 1'b1;
                  else if (wr_word == `TST_KEY_UNLOCK)
                    next_r.locked = 1'b0;
                end
                `TST_PTR_CFG: next_r.cfg = wr_word;
                `TST_PTR_HYS: next_r.hys = wr_word;
                default: next_r.hi = r.hi;
              endcase
            end
          end
        end
        tst_pkg::P_RXACK: begin
          if (scl_fall) begin
            next_r.bitcnt = 4'h0;
            if (r.rw) begin
              next_r.sh       = tx_byte;
              next_r.sda_oe_n = tx_byte[7];
              next_r.phase    = tst_pkg::P_TX;
            end else begin
              next_r.sda_oe_n = 1'b1;
              next_r.phase    = tst_pkg::P_RX;
            end
          end
        end
        tst_pkg::P_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == 4'h7) begin
              next_r.sda_oe_n = 1'b1;
              next_r.phase    = tst_pkg::P_TXACK;
            end else begin
              next_r.sh       = {r.sh[6:0], 1'b0};
              next_r.sda_oe_n = r.sh[6];
              next_r.bitcnt   = r.bitcnt + 4'h1;
            end
          end
        end
        tst_pkg::P_TXACK: begin
          if (scl_rise) begin
            // advance after each block word, wrap at end
            if (r.rd_lo && is_blk(r.ptr))
              next_r.ptr = (r.ptr == `TST_PTR_BLK_END) ? `TST_PTR_BLK
                                                      : r.ptr + 8'h01;
            next_r.rd_lo = ~r.rd_lo;
            // nack after any byte just ends the read
            next_r.phase = r.sda_f ? tst_pkg::P_WAIT : tst_pkg::P_TXNEXT;
          end
        end
        tst_pkg::P_TXNEXT: begin
          if (scl_fall) begin
            next_r.bitcnt   = 4'h0;
            next_r.sh       = tx_byte;
            next_r.sda_oe_n = tx_byte[7];
            next_r.phase    = tst_pkg::P_TX;
          end
        end
        default: next_r.phase = r.phase;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      r <= '0;
      // idle bus reads high; avoids a false start after reset
      r.scl_s1   <= 1'b1;
      r.scl_s2   <= 1'b1;
      r.sda_s1   <= 1'b1;
      r.sda_s2   <= 1'b1;
      r.scl_f    <= 1'b1;
      r.sda_f    <= 1'b1;
      r.scl_q    <= 1'b1;
      r.sda_q    <= 1'b1;
      r.addr     <= `TST_ADDR_BASE;
      r.phase    <= tst_pkg::P_IDLE;
      r.sda_oe_n <= 1'b1;
      r.cfg      <= `TST_CFG_POR;
      r.hys      <= `TST_HYS_POR;
      r.locked   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_config         = r.cfg;
  assign o_hysteresis     = r.hys;
  assign o_locked         = r.locked;
  assign o_hs_mode        = r.hs;
  assign o_soft_reset     = r.soft_rst;
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = r.sda_oe_n;

endmodule : tst_target

// [rtl/tst_controller.sv]
// byte-level two-wire bus controller, ordered by software over APB
// assumes the target never stretches SCL; SCL is made here by a divider
`timescale 1ns/1ps
`include "tst_defs.svh"

module tst_controller (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  tst_if.ctl               bus
);

  tst_pkg::tst_ctl_s r;
  tst_pkg::tst_ctl_s next_r;
  tst_pkg::tst_cmd_e cmd;
  logic              access;
  logic              tick;

  always_comb begin
    next_r = r;
    next_r.sda_s1 = bus.sda;
    next_r.sda_s2 = r.sda_s1;
    cmd    = tst_pkg::tst_cmd_e'(i_pwdata[2:0]);
    access = i_psel & i_penable & ~r.pready;
    tick   = 1'b0;
    next_r.pready  = access;
    next_r.pslverr = 1'b0;

    if (access) begin
      next_r.pslverr = (i_paddr != `TST_REG_CMD) && (i_paddr != `TST_REG_STAT);
      next_r.prdata  = 32'h0;
      if (!i_pwrite && i_paddr == `TST_REG_STAT)
        next_r.prdata = {16'h0000, r.rxb, 6'h00, r.nack_seen,
                         r.st != tst_pkg::C_IDLE};
      // orders while busy are dropped
      if (i_pwrite && i_paddr == `TST_REG_CMD && r.st == tst_pkg::C_IDLE) begin
        next_r.txb      = i_pwdata[15:8];
        next_r.rd       = (cmd == tst_pkg::CMD_READ_ACK) ||
                          (cmd == tst_pkg::CMD_READ_NACK);
        next_r.nack_out = (cmd == tst_pkg::CMD_READ_NACK);
        next_r.bitn     = 4'h0;
        next_r.q        = 2'h0;
        next_r.qcnt     = 7'h00;
        case (cmd)
          // high-speed code is sent as a start byte
          tst_pkg::CMD_START:     next_r.st = tst_pkg::C_START;
          tst_pkg::CMD_WRITE:     next_r.st = tst_pkg::C_BIT;
          tst_pkg::CMD_READ_ACK:  next_r.st = tst_pkg::C_BIT;
          tst_pkg::CMD_READ_NACK: next_r.st = tst_pkg::C_BIT;
          tst_pkg::CMD_STOP:      next_r.st = tst_pkg::C_STOP;
          default:                next_r.st = tst_pkg::C_IDLE;
        endcase
      end
    end

    // quarter-bit divider keeps SCL well above 1 kHz
    if (r.st != tst_pkg::C_IDLE) begin
      if (r.qcnt == 7'(`TST_SCL_QTR_CYC - 1)) begin
        next_r.qcnt = 7'h00;
        tick        = 1'b1;
      end else begin
        next_r.qcnt = r.qcnt + 7'h01;
      end
    end

    if (tick) begin
      next_r.q = r.q + 2'h1;
      case (r.st)
        tst_pkg::C_START: begin
          case (r.q)
            2'h0: next_r.sda_oe_n = 1'b1;
            2'h1: next_r.scl_oe_n = 1'b1;
            2'h2: next_r.sda_oe_n = 1'b0;
            default: begin
              next_r.scl_oe_n = 1'b0;
              next_r.st       = tst_pkg::C_BIT;
            end
          endcase
        end
        tst_pkg::C_BIT: begin
          case (r.q)
            2'h0: begin
              // ack slot: release on write and on read-nack, drive on read-ack
              if (r.bitn == 4'h8)
                next_r.sda_oe_n = r.rd ? r.nack_out : 1'b1;
              else
                next_r.sda_oe_n = r.rd ? 1'b1 : r.txb[7];
            end
            2'h1: next_r.scl_oe_n = 1'b1;
            2'h2: begin
              if (r.rd && r.bitn != 4'h8)
                next_r.rxb = {r.rxb[6:0], r.sda_s2};
              if (!r.rd && r.bitn == 4'h8)
                next_r.nack_seen = r.sda_s2;
            end
            default: begin
              next_r.scl_oe_n = 1'b0;
              next_r.txb      = {r.txb[6:0], 1'b0};
              next_r.bitn     = r.bitn + 4'h1;
              if (r.bitn == 4'h8)
                next_r.st = tst_pkg::C_IDLE;
            end
          endcase
        end
        tst_pkg::C_STOP: begin
          case (r.q)
            2'h0: next_r.sda_oe_n = 1'b0;
            2'h1: next_r.scl_oe_n = 1'b1;
            2'h2: next_r.sda_oe_n = 1'b1;
            default: next_r.st = tst_pkg::C_IDLE;
          endcase
        end
        default: next_r.q = 2'h0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      r          <= '0;
      r.sda_s1   <= 1'b1;
      r.sda_s2   <= 1'b1;
      r.st       <= tst_pkg::C_IDLE;
      r.scl_oe_n <= 1'b1;
      r.sda_oe_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_prdata         = r.prdata;
  assign o_pready         = r.pready;
  assign o_pslverr        = r.pslverr;
  assign bus.ctl_scl_o    = 1'b0;
  assign bus.ctl_scl_oe_n = r.scl_oe_n;
  assign bus.ctl_sda_o    = 1'b0;
  assign bus.ctl_sda_oe_n = r.sda_oe_n;

endmodule : tst_controller

// [verif/tst_asserts.sv]
// checker on the open-drain two-wire bus between both ends
// assumes one 125 MHz domain; lines read high while released
`timescale 1ns/1ps
module tst_asserts #(
  parameter int TIMEOUT_CYC = 2000
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_scl_o,
  input wire logic ctl_sda_o,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n
);
  // low run of each line; saturates
  logic [31:0] low_cnt;
  logic [31:0] sda_low_cnt;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n || scl) begin
      low_cnt <= 32'h0;
    end else if (low_cnt != 32'hFFFFFFFF) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n || sda) begin
      sda_low_cnt <= 32'h0;
    end else if (sda_low_cnt != 32'hFFFFFFFF) begin
      sda_low_cnt <= sda_low_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  AST_START_HOLD: assert property ($fell(sda) && scl |-> scl[*8])
    else $error("scl fell right after start");
  AST_STOP_HOLD: assert property ($rose(sda) && scl |-> sda[*8])
    else $error("sda fell right after stop");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  AST_SCL_LOW: assert property ($fell(scl) |-> (!scl)[*8])
    else $error("scl low phase too short");
  AST_DRV_SETUP: assert property ($fell(dev_sda_oe_n) |-> !scl)
    else $error("target took sda while scl high");
  AST_DRV_HOLD: assert property ($rose(dev_sda_oe_n) |-> !scl)
    else $error("target let sda go while scl high");
  AST_OPEN_DRAIN: assert property (!dev_sda_o && !ctl_scl_o && !ctl_sda_o)
    else $error("a line driven high");
  // slack covers sync and filter lag
  AST_TMO_FREE: assert property ((low_cnt > TIMEOUT_CYC + 16) || (sda_low_cnt > TIMEOUT_CYC + 16) |-> dev_sda_oe_n)
    else $error("target still holds sda after timeout");
endmodule : tst_asserts

// [verif/sensor_two_wire_target_port_tb_top.sv]
// bench: controller end ordered over apb talks to the target end
// assumes a short timeout parameter; strap fixed at address 4A
`timescale 1ns/1ps
module sensor_two_wire_target_port_tb_top;
  // must outlast the longest legal low run (a zero word)
  localparam int         TMO = 8000;
  localparam logic [6:0] DEV = 7'h4A;
  logic             i_clock, i_reset_n, psel, penable, pwrite;
  logic             pready, pslverr, locked, hs, srst, srst_seen, nk;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, st;
  logic [1:0]       addr_sel;
  logic [8:0][15:0] temps;
  logic [15:0]      cfg, hys;
  logic [7:0]       rb [0:3];
  int               error_cnt, tests_run;

  tst_if bus_if ();
  tst_target #(.TIMEOUT_CYC(TMO)) tst_target_inst (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_addr_sel(addr_sel), .i_temps(temps),
    .o_config(cfg), .o_hysteresis(hys), .o_locked(locked),
    .o_hs_mode(hs), .o_soft_reset(srst), .bus(bus_if));
  tst_controller tst_controller_inst (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .bus(bus_if));
  tst_asserts #(.TIMEOUT_CYC(TMO)) tst_asserts_inst (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .scl(bus_if.scl), .sda(bus_if.sda),
    .ctl_scl_o(bus_if.ctl_scl_o), .ctl_sda_o(bus_if.ctl_sda_o),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe_n(bus_if.dev_sda_oe_n));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // pulse is one cycle wide, so latch it
  always @(posedge i_clock) begin
    if (srst === 1'b1) srst_seen <= 1'b1;
  end

  task conclude;
    $display("checks %0d bad %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // entered just after a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) @(posedge i_clock);
    st = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clock);
  endtask : apb

  task op(input logic [2:0] c, input logic [7:0] b);
    apb(1'b1, 8'h00, {16'h0, b, 5'h0, c});
    do apb(1'b0, 8'h04, 32'h0); while (st[0] !== 1'b0);
  endtask : op

  task wr(input logic [7:0] p, input logic [15:0] w, input int nb);
    op(3'h1, {DEV, 1'b0});
    op(3'h2, p);
    if (nb > 0) op(3'h2, w[15:8]);
    nk = st[1];
    if (nb > 1) op(3'h2, w[7:0]);
    op(3'h5, 8'h00);
  endtask : wr

  task rd(input int n);
    op(3'h1, {DEV, 1'b1});
    for (int i = 0; i < n; i++) begin
      op((i == n - 1) ? 3'h4 : 3'h3, 8'h00);
      rb[i] = st[15:8];
    end
    op(3'h5, 8'h00);
  endtask : rd

  task t_addr;
    op(3'h1, {7'h48, 1'b0});
    chk("foreign addr", st[1], 1); // not ours
    op(3'h5, 8'h00);
    op(3'h1, {DEV, 1'b0});
    chk("strap addr", st[1], 0); // strap match
    op(3'h5, 8'h00);
    $display("t_addr done");
  endtask : t_addr

  task t_single;
    wr(8'h03, 16'h0, 0);
    rd(1);
    chk("short read", rb[0], temps[3][15:8]); // hi only
    rd(2);
    chk("again hi", rb[0], temps[3][15:8]); // restart hi
    chk("then lo", rb[1], temps[3][7:0]); // same pointer
    $display("t_single done");
  endtask : t_single

  task t_block;
    wr(8'h87, 16'h0, 0);
    rd(2);
    chk("blk 7", {rb[0], rb[1]}, temps[7]); // mirror
    rd(4);
    chk("blk 8", {rb[0], rb[1]}, temps[8]); // advanced
    chk("blk wrap", {rb[2], rb[3]}, temps[0]); // wrap
    $display("t_block done");
  endtask : t_block

  task t_lock;
    chk("pwr lock", locked, 1); // starts locked
    wr(8'h38, 16'h1111, 2);
    chk("lock nack", nk, 1); // data refused
    chk("hys kept", hys, 16'h0500); // dropped
    wr(8'hC4, 16'hEB19, 2);
    chk("unlock", locked, 0); // key clears
    wr(8'h30, 16'h1234, 2);
    chk("cfg word", cfg, 16'h1234); // commit
    wr(8'h38, 16'hAB00, 1);
    chk("odd drop", hys, 16'h0500); // half word
    wr(8'hC4, 16'h5CA6, 2);
    chk("relock", locked, 1); // key sets
    wr(8'h20, 16'h8000, 2);
    chk("srst", srst_seen, 1); // pulse
    chk("cfg por", cfg, 16'hFF9C); // restored
    $display("t_lock done");
  endtask : t_lock

  task t_hs;
    op(3'h1, 8'h09);
    chk("hs nack", st[1], 1); // code unacked
    chk("hs on", hs, 1); // filters switch
    op(3'h1, {DEV, 1'b0});
    chk("hs stays", hs, 1); // kept
    op(3'h5, 8'h00);
    chk("hs off", hs, 0); // stop ends
    $display("t_hs done");
  endtask : t_hs

  // pointer is 20h here, so the target drives a zero bit
  task t_tmo;
    op(3'h1, {DEV, 1'b1});
    repeat (1000) @(posedge i_clock);
    chk("sda held", bus_if.sda, 0); // not yet
    repeat (TMO) @(posedge i_clock);
    chk("sda freed", bus_if.sda, 1); // released
    op(3'h5, 8'h00);
    op(3'h1, {DEV, 1'b0});
    chk("fresh start", st[1], 0); // answers again
    op(3'h5, 8'h00);
    $display("t_tmo done");
  endtask : t_tmo

  initial begin
    i_reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    addr_sel = 2'h2;
    srst_seen = 1'b0;
    nk = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    for (int i = 0; i < 9; i++) temps[i] = 16'h1234 + 16'(i) * 16'h0101;
    repeat (5) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (5) @(posedge i_clock);
    t_addr;
    t_single;
    t_block;
    t_lock;
    t_hs;
    t_tmo;
    conclude;
  end

  initial begin
    repeat (400000) @(posedge i_clock);
    error_cnt++;
    conclude;
  end
endmodule : sensor_two_wire_target_port_tb_top
